// >>> hw/sgc_global_ctl.sv
/*
 * sgc_global_ctl: identity / run register and global control register one,
 * with the frame accept decision, flow control gating and aging control
 * that those bits steer. Assumes a synchronous 16-bit host register port,
 * per-port link status straight from pins, one frame descriptor per cycle.
 */
// Function
// - the identity register shows fixed family, chip and revision codes that writes cannot change.
// - identity bit 0 is a run bit, reset to one, where zero disables the switch.
// - control bit 15 forwards bad frames too, but only while the frame is in sniffer mode.
// - control bit 14 accepts frames up to 2000 bytes, otherwise bit 4 or the second register's size bits set the limit.
// - control bit 13, reset to one, allows pause generation and when clear no pause is sent.
// - control bit 12, reset to one, lets received pause frames act and when clear they are ignored.
// - control bit 11 drops frames whose length field below 1500 disagrees with the real length.
// - control bit 10, reset to one, enables aging of learned addresses.
// - control bit 9 selects the fast aging period of about 800 us.
// - control bit 8 selects the aggressive half-duplex back-off.
// - control bit 5 sends a pause on ingress rate excess when set and drops the frame when clear.
// - control bit 4, reset to one, allows 2000-byte frames and overrides the second register's size bits.
// - control bit 3 passes pause frames instead of filtering them.
// - with control bit 0 set, link loss starts one fast aging cycle, then normal aging resumes.
// - any link loss ages out every learned address.
`timescale 1ns/1ps
module sgc_global_ctl #(
  parameter int              NPORT       = 2,
  parameter logic [7:0]      FAMILY_CODE = 8'h5A,  // arbitrary value
  parameter logic [3:0]      CHIP_CODE   = 4'hC,   // arbitrary value
  parameter logic [2:0]      REV_CODE    = 3'h5,   // arbitrary value
  parameter longint unsigned NORM_CYC    = sgc_pkg::NORM_AGE_CYC,
  parameter longint unsigned FAST_CYC    = sgc_pkg::FAST_AGE_CYC
) (
  // clock and reset
  input  wire logic             I_REF_CLK,
  input  wire logic             I_ARST_N,
  // host register port
  input  wire logic [7:0]       I_ADDR,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  input  wire logic [1:0]       I_BE,
  input  wire logic [15:0]      I_WDATA,
  output logic [15:0]           O_RDATA,
  output logic                  O_RVALID,
  // link status pins
  input  wire logic [NPORT-1:0] I_LINK_UP,
  // frame decision
  input  sgc_pkg::sgc_frm_t     I_FRM,
  input  wire logic [10:0]      I_ALT_MAX_LEN,
  output logic                  O_FRM_DONE,
  output logic                  O_FRM_FWD,
  output logic                  O_FRM_DROP,
  output logic                  O_PAUSE_HONOR,
  // flow control and mac settings
  input  wire logic             I_FC_REQ,
  output logic                  O_PAUSE_GEN,
  output logic                  O_AGGR_BACKOFF,
  output logic                  O_RUN,
  output sgc_pkg::sgc_ctl_t     O_CTL,
  // aging
  output logic                  O_AGE_TICK,
  output logic                  O_AGE_ALL
);

  // ************************************************************
  // registers
  // ************************************************************
  logic        run_q;
  logic        run_d;
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;
  logic [15:0] id_word;
  logic        hit_id;
  logic        hit_ctl;

  assign hit_id  = (I_ADDR == sgc_pkg::OFS_ID_RUN);
  assign hit_ctl = (I_ADDR == sgc_pkg::OFS_CTL_ONE);
  assign id_word = {FAMILY_CODE, CHIP_CODE, REV_CODE, run_q};

  always_comb begin
    run_d   = run_q;
    ctl_d   = ctl_q;
    rdata_d = rdata_q;
    if (I_WR && hit_id && I_BE[0]) begin
      run_d = I_WDATA[sgc_pkg::ID_RUN_BIT];
    end
    if (I_WR && hit_ctl) begin
      // reserved bits are stored as written, software keeps them
      if (I_BE[0]) begin
        ctl_d[7:0] = I_WDATA[7:0];
      end
      if (I_BE[1]) begin
        ctl_d[15:8] = I_WDATA[15:8];
      end
    end
    if (I_RD) begin
      // unmapped offsets read as zero
      rdata_d = hit_id ? id_word : (hit_ctl ? ctl_q : 16'h0000);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      run_q    <= sgc_pkg::RUN_RST;
      ctl_q    <= sgc_pkg::CTL_ONE_RST;
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      run_q    <= run_d;
      ctl_q    <= ctl_d;
      rdata_q  <= rdata_d;
      rvalid_q <= I_RD;
    end
  end

  assign O_RDATA  = rdata_q;
  assign O_RVALID = rvalid_q;
  assign O_RUN    = run_q;

  assign O_CTL.pass_all     = ctl_q[sgc_pkg::CB_PASS_ALL];
  assign O_CTL.rx2000       = ctl_q[sgc_pkg::CB_RX2000];
  assign O_CTL.tx_fc        = ctl_q[sgc_pkg::CB_TX_FC];
  assign O_CTL.rx_fc        = ctl_q[sgc_pkg::CB_RX_FC];
  assign O_CTL.len_chk      = ctl_q[sgc_pkg::CB_LEN_CHK];
  assign O_CTL.age_en       = ctl_q[sgc_pkg::CB_AGE_EN];
  assign O_CTL.fast_age     = ctl_q[sgc_pkg::CB_FAST_AGE];
  assign O_CTL.aggr_backoff = ctl_q[sgc_pkg::CB_AGGR_BO];
  assign O_CTL.rate_fc      = ctl_q[sgc_pkg::CB_RATE_FC];
  assign O_CTL.rx2k         = ctl_q[sgc_pkg::CB_RX2K];
  assign O_CTL.pass_pause   = ctl_q[sgc_pkg::CB_PASS_PAUSE];
  assign O_CTL.link_age     = ctl_q[sgc_pkg::CB_LINK_AGE];
  assign O_AGGR_BACKOFF     = ctl_q[sgc_pkg::CB_AGGR_BO];

  // ************************************************************
  // frame accept decision
  // ************************************************************
  logic [10:0] max_len;
  logic        too_long;
  logic        len_bad;
  logic        err_drop;
  logic        pause_drop;
  logic        rate_drop;
  logic        drop_d;
  logic        done_q;
  logic        drop_q;
  logic        honor_q;
  logic        honor_d;

  always_comb begin
    // either long-frame bit overrides the second register's limit
    max_len    = (ctl_q[sgc_pkg::CB_RX2000] || ctl_q[sgc_pkg::CB_RX2K]) ?
                 sgc_pkg::MAX_LEN_LONG : I_ALT_MAX_LEN;
    // second register's limit is capped too, nothing over 2000 gets in
    too_long   = (I_FRM.len > max_len) || (I_FRM.len > sgc_pkg::MAX_LEN_LONG);
    len_bad    = ctl_q[sgc_pkg::CB_LEN_CHK] && (I_FRM.len_type < sgc_pkg::LEN_FIELD_TOP) &&
                 (I_FRM.len_type != {5'h00, I_FRM.payload_len});
    err_drop   = I_FRM.bad && !(ctl_q[sgc_pkg::CB_PASS_ALL] && I_FRM.sniff);
    pause_drop = I_FRM.pause && !ctl_q[sgc_pkg::CB_PASS_PAUSE];
    rate_drop  = I_FRM.rate_exceed && !ctl_q[sgc_pkg::CB_RATE_FC];
    drop_d     = !run_q || too_long || len_bad || err_drop || pause_drop || rate_drop;
    honor_d    = I_FRM.valid && I_FRM.pause && run_q && ctl_q[sgc_pkg::CB_RX_FC];
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      done_q  <= 1'b0;
      drop_q  <= 1'b0;
      honor_q <= 1'b0;
    end else begin
      done_q  <= I_FRM.valid;
      drop_q  <= I_FRM.valid && drop_d;
      honor_q <= honor_d;
    end
  end

  assign O_FRM_DONE    = done_q;
  assign O_FRM_DROP    = drop_q;
  assign O_FRM_FWD     = done_q && !drop_q;
  assign O_PAUSE_HONOR = honor_q;

  // ************************************************************
  // pause generation
  // ************************************************************
  logic pause_q;
  logic pause_d;

  assign pause_d = run_q && ctl_q[sgc_pkg::CB_TX_FC] &&
                   (I_FC_REQ || (I_FRM.valid && I_FRM.rate_exceed &&
                   ctl_q[sgc_pkg::CB_RATE_FC]));

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= pause_d;
    end
  end

  assign O_PAUSE_GEN = pause_q;

  // ************************************************************
  // link loss and aging
  // ************************************************************
  logic [NPORT-1:0] link_s1_q;
  logic [NPORT-1:0] link_s2_q;
  logic [NPORT-1:0] link_s3_q;
  logic [NPORT-1:0] link_fall;
  logic             link_lost;
  logic             once_q;
  logic             once_d;
  logic             all_q;
  logic             tick;
  logic             age_run;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_link
      // pins are async, only s2 onward is looked at
      always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          link_s1_q[gp] <= 1'b0;
          link_s2_q[gp] <= 1'b0;
          link_s3_q[gp] <= 1'b0;
        end else begin
          link_s1_q[gp] <= I_LINK_UP[gp];
          link_s2_q[gp] <= link_s1_q[gp];
          link_s3_q[gp] <= link_s2_q[gp];
        end
      end
      assign link_fall[gp] = link_s3_q[gp] && !link_s2_q[gp];
    end
  endgenerate

  assign link_lost = |link_fall;
  assign age_run   = run_q && ctl_q[sgc_pkg::CB_AGE_EN];

  always_comb begin
    once_d = once_q;
    if (tick || !age_run) begin
      once_d = 1'b0;
    end
    // a new loss in the tick cycle still starts a fresh fast cycle
    if (link_lost && ctl_q[sgc_pkg::CB_LINK_AGE] && age_run) begin
      once_d = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      once_q <= 1'b0;
      all_q  <= 1'b0;
    end else begin
      once_q <= once_d;
      all_q  <= link_lost;
    end
  end

  sgc_age_timer #(
    .NORM_CYC (NORM_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_age (
    .i_clk     (I_REF_CLK),
    .i_arst_n  (I_ARST_N),
    .i_en      (age_run),
    .i_fast    (ctl_q[sgc_pkg::CB_FAST_AGE] || once_q),
    .i_restart (link_lost && ctl_q[sgc_pkg::CB_LINK_AGE]),
    .o_tick    (tick)
  );

  assign O_AGE_TICK = tick;
  assign O_AGE_ALL  = all_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_id_fields_ro: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    O_RVALID && $past(I_RD) && $past(I_ADDR) == sgc_pkg::OFS_ID_RUN |->
    O_RDATA[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity fields read wrong");

  a_run_write: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_WR && hit_id && I_BE[0] |=> O_RUN == $past(I_WDATA[0]))
    else $error("run bit did not take write");

  a_stopped_drop: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_FRM.valid && !run_q |=> O_FRM_DROP && !O_FRM_FWD)
    else $error("frame passed while stopped");

  a_long_drop: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_FRM.valid && I_FRM.len > sgc_pkg::MAX_LEN_LONG |=> O_FRM_DROP)
    else $error("overlong frame kept");

  a_bad_filter: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_FRM.valid && I_FRM.bad && !I_FRM.sniff |=> O_FRM_DROP)
    else $error("bad frame forwarded outside sniffer");

  a_txfc_gate: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    !ctl_q[sgc_pkg::CB_TX_FC] |=> !O_PAUSE_GEN)
    else $error("pause sent with tx flow control off");

  a_rxfc_gate: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    O_PAUSE_HONOR |-> $past(ctl_q[sgc_pkg::CB_RX_FC]) && $past(I_FRM.pause))
    else $error("pause honoured while ignored");

  a_len_field: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_FRM.valid && ctl_q[sgc_pkg::CB_LEN_CHK] && I_FRM.len_type < 16'd1500 &&
    I_FRM.len_type != {5'h00, I_FRM.payload_len} |=> O_FRM_DROP)
    else $error("length field mismatch kept");

  a_age_off: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    !ctl_q[sgc_pkg::CB_AGE_EN] [*2] |-> !O_AGE_TICK)
    else $error("aging tick while disabled");

  a_pause_filter: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    I_FRM.valid && I_FRM.pause && !ctl_q[sgc_pkg::CB_PASS_PAUSE] |=> O_FRM_DROP)
    else $error("pause frame not filtered");

  a_link_age_all: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
    link_lost |=> O_AGE_ALL)
    else $error("link loss did not age out table");

endmodule

// >>> hw/sgc_pkg.sv
/*
 * sgc_pkg: register map, field positions, reset values, timing counts and
 * carrier types for the switch identity / global control register bank.
 * Assumes a single 250 MHz reference clock shared by every user of it.
 */
package sgc_pkg;

  // ************************************************************
  // register map (byte offsets on the 16-bit host register port)
  // ************************************************************
  localparam logic [7:0]  OFS_ID_RUN   = 8'h00;
  localparam logic [7:0]  OFS_CTL_ONE  = 8'h02;

  // identity / run fields
  localparam int          ID_FAMILY_LSB = 8;
  localparam int          ID_CHIP_LSB   = 4;
  localparam int          ID_REV_LSB    = 1;
  localparam int          ID_RUN_BIT    = 0;
  localparam logic        RUN_RST       = 1'b1;

  // control one fields
  localparam int          CB_PASS_ALL   = 15;
  localparam int          CB_RX2000     = 14;
  localparam int          CB_TX_FC      = 13;
  localparam int          CB_RX_FC      = 12;
  localparam int          CB_LEN_CHK    = 11;
  localparam int          CB_AGE_EN     = 10;
  localparam int          CB_FAST_AGE   = 9;
  localparam int          CB_AGGR_BO    = 8;
  localparam int          CB_RATE_FC    = 5;
  localparam int          CB_RX2K       = 4;
  localparam int          CB_PASS_PAUSE = 3;
  localparam int          CB_LINK_AGE   = 0;
  localparam logic [15:0] CTL_ONE_RST   = 16'h3450;

  // frame length figures
  localparam logic [10:0] MAX_LEN_LONG  = 11'd2000;
  localparam logic [15:0] LEN_FIELD_TOP = 16'd1500;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint unsigned CLK_MHZ      = 250;
  localparam longint unsigned FAST_AGE_US  = 800;
  localparam longint unsigned NORM_AGE_S   = 300 + 75;
  // longest times, so round up
  localparam longint unsigned FAST_AGE_CYC = FAST_AGE_US * CLK_MHZ;
  localparam longint unsigned NORM_AGE_CYC = NORM_AGE_S * CLK_MHZ * 64'd1000000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        valid;
    logic        bad;
    logic        pause;
    logic        rate_exceed;
    logic        sniff;
    logic [10:0] len;
    logic [15:0] len_type;
    logic [10:0] payload_len;
  } sgc_frm_t;

  typedef struct packed {
    logic pass_all;
    logic rx2000;
    logic tx_fc;
    logic rx_fc;
    logic len_chk;
    logic age_en;
    logic fast_age;
    logic aggr_backoff;
    logic rate_fc;
    logic rx2k;
    logic pass_pause;
    logic link_age;
  } sgc_ctl_t;

endpackage

// >>> hw/sgc_age_timer.sv
/*
 * sgc_age_timer: free-running aging period counter with a normal and a
 * fast period. Assumes the caller gates it and restarts it synchronously.
 */
`timescale 1ns/1ps
module sgc_age_timer #(
  parameter int              CW       = 40,
  parameter longint unsigned NORM_CYC = sgc_pkg::NORM_AGE_CYC,
  parameter longint unsigned FAST_CYC = sgc_pkg::FAST_AGE_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // control
  input  wire logic i_en,
  input  wire logic i_fast,
  input  wire logic i_restart,
  // event
  output logic      o_tick
);

  // ************************************************************
  // period counter
  // ************************************************************
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] last;
  logic          tick_d;
  logic          tick_q;

  always_comb begin
    last   = i_fast ? CW'(FAST_CYC - 1) : CW'(NORM_CYC - 1);
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!i_en || i_restart) begin
      cnt_d = '0;
    end else if (cnt_q >= last) begin
      // >= so a switch to the short period ends at once
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;

endmodule

// >>> tb/tb.sv
/*
 * tb: self-checking bench for sgc_global_ctl covering register reads and
 * writes, frame decisions, pause outputs, aging periods and link loss.
 * Assumes short aging counts passed in by parameter and a 250 MHz clock.
 */
`timescale 1ns/1ps
module tb;
  // ************************************************************
  // setup
  // ************************************************************
  localparam int       NORM = 200;
  localparam int       FAST = 20;
  localparam logic [15:0] ID_EXP = 16'h5ACA;  // arbitrary codes set below
  logic                clk;
  logic                arst_n;
  logic                wr;
  logic                rd;
  logic                fcreq;
  logic                rvalid;
  logic [7:0]          addr;
  logic [1:0]          be;
  logic [1:0]          link;
  logic [15:0]         wdata;
  logic [15:0]         rdata;
  logic [15:0]         ctl_m;
  logic [10:0]         alt;
  logic                done;
  logic                fwd;
  logic                drop;
  logic                honor;
  logic                pgen;
  logic                aggr;
  logic                run;
  logic                tick;
  logic                ageall;
  logic                run_m;
  sgc_pkg::sgc_frm_t   frm;
  sgc_pkg::sgc_ctl_t   ctl;
  logic [15:0]         rq[$];
  logic [3:0]          fq[$];
  int                  num_errors = 0;
  int                  compares = 0;
  int                  n;

  sgc_global_ctl #(.NPORT(2), .FAMILY_CODE(8'h5A), .CHIP_CODE(4'hC), .REV_CODE(3'h5),
    .NORM_CYC(NORM), .FAST_CYC(FAST)) sgc_global_ctl_i (
    .I_REF_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
    .I_BE(be), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
    .I_LINK_UP(link), .I_FRM(frm), .I_ALT_MAX_LEN(alt), .O_FRM_DONE(done),
    .O_FRM_FWD(fwd), .O_FRM_DROP(drop), .O_PAUSE_HONOR(honor), .I_FC_REQ(fcreq),
    .O_PAUSE_GEN(pgen), .O_AGGR_BACKOFF(aggr), .O_RUN(run), .O_CTL(ctl),
    .O_AGE_TICK(tick), .O_AGE_ALL(ageall));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ************************************************************
  // compare and report
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_frm(input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] drop/fwd/honor/pausegen expected %b seen %b", exp, got);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [15:0] ctl_exp(input logic [15:0] v);
    return {4'h0, v[15:8], v[5:3], v[0]};
  endfunction

  task automatic check_state();
    chk("ctl bits", ctl_exp(ctl_m), {4'h0, ctl});
    chk("back-off", {15'h0, ctl_m[8]}, {15'h0, aggr});
    chk("run", {15'h0, run_m}, {15'h0, run});
  endtask

  // ************************************************************
  // drivers, all on the falling edge
  // ************************************************************
  task automatic reg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(negedge clk);
    if (a == 8'h02) d = (d & 16'hFF39) | (ctl_m & 16'h00C6);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    if (a == 8'h02 && b[0]) ctl_m[7:0] = d[7:0];
    if (a == 8'h02 && b[1]) ctl_m[15:8] = d[15:8];
    if (a == 8'h00 && b[0]) run_m = d[0];
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    rq.push_back(a == 8'h00 ? (ID_EXP | {15'h0, run_m}) : (a == 8'h02 ? ctl_m : 16'h0));
    @(negedge clk);
    rd = 1'b0;
  endtask

  // back to back frames; expectation noted as each is sent
  task automatic frm_burst(input int cnt);
    logic        d;
    logic [10:0] lim;
    for (int i = 0; i < cnt; i++) begin
      @(negedge clk);
      frm.valid = 1'b1;
      frm.bad = ($urandom % 4) == 0;
      frm.pause = ($urandom % 4) == 0;
      frm.rate_exceed = ($urandom % 4) == 0;
      frm.sniff = 1'($urandom);
      frm.len = ($urandom % 2) ? 11'($urandom_range(1995, 2005)) : 11'($urandom);
      frm.payload_len = 11'($urandom);
      frm.len_type = ($urandom % 2) ? {5'h0, frm.payload_len} + 16'($urandom % 2)
                                    : 16'($urandom_range(1400, 1600));
      alt = 11'($urandom);
      fcreq = 1'($urandom);
      lim = (ctl_m[14] || ctl_m[4]) ? 11'd2000 : alt;
      d = !run_m || frm.len > lim || frm.len > 11'd2000 || (frm.bad && !(ctl_m[15] && frm.sniff))
        || (ctl_m[11] && frm.len_type < 16'd1500 && frm.len_type != {5'h0, frm.payload_len})
        || (frm.pause && !ctl_m[3]) || (frm.rate_exceed && !ctl_m[5]);
      fq.push_back({d, !d, frm.pause && run_m && ctl_m[12],
                    run_m && ctl_m[13] && (fcreq || (frm.rate_exceed && ctl_m[5]))});
    end
    @(negedge clk);
    frm.valid = 1'b0;
    fcreq = 1'b0;
  endtask

  task automatic wait_tick(input int lim, output int k);
    for (k = 1; k < lim; k++) begin
      @(negedge clk);
      if (tick === 1'b1) return;
    end
  endtask

  task automatic wait_flush(output int k);
    for (k = 1; k < 9; k++) begin
      @(negedge clk);
      if (ageall === 1'b1) return;
    end
  endtask

  // ************************************************************
  // result monitor
  // ************************************************************
  always @(negedge clk) begin
    if (arst_n === 1'b1 && rvalid === 1'b1) begin
      if (rq.size() == 0) chk("stray read", 16'h0, 16'hFFFF);
      else chk("read data", rq.pop_front(), rdata);
    end
    if (arst_n === 1'b1 && done === 1'b1) begin
      if (fq.size() == 0) chk_frm(4'h0, 4'hF);
      else chk_frm(fq.pop_front(), {drop, fwd, honor, pgen});
    end
  end

  // hang guard, well above the expected run of under 2000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    final_report();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {arst_n, wr, rd, fcreq, addr, be, wdata, alt} = '0;
    frm = '0;
    link = 2'b11;
    ctl_m = 16'h3450;
    run_m = 1'b1;
    n = $urandom(69);
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    check_state();
    reg_rd(8'h00);
    reg_rd(8'h02);
    reg_rd(8'h04);
    $display("test reset values done");
    reg_wr(8'h00, 2'b11, 16'hA534);
    check_state();
    reg_rd(8'h00);
    reg_wr(8'h00, 2'b10, 16'hFFFF);
    reg_rd(8'h00);
    reg_wr(8'h00, 2'b01, 16'h0001);
    check_state();
    $display("test identity and run done");
    repeat (8) begin
      reg_wr(8'h02, 2'($urandom), 16'($urandom));
      check_state();
      reg_rd(8'h02);
    end
    $display("test control lanes done");
    repeat (14) begin
      reg_wr(8'h02, 2'b11, 16'($urandom));
      reg_wr(8'h00, 2'b01, {15'h0, ($urandom % 4) != 0});
      frm_burst(8);
    end
    $display("test frame decisions done");
    // last burst may have left the switch stopped, aging needs it running
    reg_wr(8'h00, 2'b01, 16'h0001);
    reg_wr(8'h02, 2'b11, 16'h0400);
    wait_tick(500, n);
    wait_tick(500, n);
    chk("normal period", 16'(NORM), 16'(n));
    reg_wr(8'h02, 2'b11, 16'h0600);
    wait_tick(500, n);
    wait_tick(500, n);
    chk("fast period", 16'(FAST), 16'(n));
    reg_wr(8'h02, 2'b11, 16'h0000);
    wait_tick(450, n);
    chk("aging off", 16'd450, 16'(n));
    $display("test aging periods done");
    reg_wr(8'h02, 2'b11, 16'h0401);
    wait_tick(500, n);
    @(negedge clk);
    link = 2'b01;
    wait_flush(n);
    chk("flush on loss", 16'h1, {15'h0, n < 9});
    wait_tick(500, n);
    chk("one fast cycle", 16'h1, {15'h0, n <= FAST + 8});
    wait_tick(500, n);
    chk("normal resumes", 16'(NORM), 16'(n));
    reg_wr(8'h02, 2'b11, 16'h0400);
    link = 2'b11;
    repeat (8) @(negedge clk);
    link = 2'b10;
    wait_flush(n);
    chk("flush without bit0", 16'h1, {15'h0, n < 9});
    $display("test link loss done");
    @(negedge clk);
    arst_n = 1'b0;
    ctl_m = 16'h3450;
    run_m = 1'b1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    check_state();
    reg_rd(8'h00);
    repeat (4) @(negedge clk);
    chk("results left", 16'h0, 16'(rq.size() + fq.size()));
    $display("test second reset done");
    final_report();
  end
endmodule
